// File: verilog/ascp_pkg.sv
// Shared constants and types of the converter serial control port.
// Assumes one system clock domain plus the host-driven serial clock.
package ascp_pkg;
    // Result and storage shape
    localparam int ASCP_RES_BITS = 12;
    localparam int ASCP_WORD_BITS = 16;
    localparam int ASCP_FIFO_DEPTH = 8;
    localparam int ASCP_CHANNELS = 16;
    localparam int ASCP_PAIRS = 8;
    // Clock modes held in timing_source_select
    localparam logic [1:0] ASCP_MODE_TRIG_SCAN = 2'h0;
    localparam logic [1:0] ASCP_MODE_TRIG_SINGLE = 2'h1;
    localparam logic [1:0] ASCP_MODE_SERIAL = 2'h2;
    localparam logic [1:0] ASCP_MODE_EXT = 2'h3;
    localparam logic [1:0] ASCP_MODE_RESET = ASCP_MODE_SERIAL;
    // Command byte fields
    localparam int ASCP_CONV_FLAG_BIT = 7;
    localparam int ASCP_CHAN_MSB = 6;
    localparam int ASCP_CHAN_LSB = 3;
    localparam int ASCP_TEMP_BIT = 0;
    localparam int ASCP_TAG_MSB = 7;
    localparam int ASCP_TAG_LSB = 6;
    localparam logic [1:0] ASCP_SETUP_TAG = 2'h1;
    localparam int ASCP_MODE_MSB = 5;
    localparam int ASCP_MODE_LSB = 4;
    localparam int ASCP_DIFF_MSB = 1;
    localparam int ASCP_DIFF_LSB = 0;
    localparam logic [1:0] ASCP_DIFF_NONE = 2'h0;
    localparam logic [1:0] ASCP_DIFF_UNI = 2'h2;
    localparam logic [1:0] ASCP_DIFF_BIP = 2'h3;
    // Reset values
    localparam logic [7:0] ASCP_PAIR_RESET = 8'h00;
    localparam logic [3:0] ASCP_CHAN_RESET = 4'h0;
    localparam logic [11:0] ASCP_TRIAL_RESET = 12'h800;
    localparam logic [3:0] ASCP_TOP_BIT = 4'hB;
    // Cycles the comparator path needs after each trial code change
    localparam logic [1:0] ASCP_SAR_SETTLE = 2'h3;
    typedef enum logic [1:0] {ASCP_IDLE, ASCP_SAR, ASCP_PUSH} ascp_state_t;
endpackage

// File: verilog/ascp_serial_port.sv
// Serial control port and conversion sequencer of a 12-bit SAR converter.
// Assumes a host master on spi_*, an analog comparator on cmp_hi.
`timescale 1ns/10ps
`default_nettype none

module ascp_fifo #(
    parameter int WIDTH = ascp_pkg::ASCP_WORD_BITS,
    parameter int DEPTH = ascp_pkg::ASCP_FIFO_DEPTH
) (
    // System
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
            $error("ascp_fifo depth must be a power of two");
        end
    endgenerate
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0] cnt_ff;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;
    assign in_ready = cnt_ff != (AW+1)'(DEPTH);
    assign out_valid = cnt_ff != '0;
    assign out_data = mem[rd_ff];
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ff] <= in_data;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= rd_ff + 1'b1;
            end
            if (push && !pop) begin
                cnt_ff <= cnt_ff + 1'b1;
            end else if (pop && !push) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end
endmodule

// Contract
// - Serial traffic only while chip select low
// - Data output released while chip select high
// - Input bits sampled on rising serial clock
// - Output bits change on falling serial clock
// - End-of-conversion low once result valid
// - Shared pin: active-low trigger or top channel
// - Twelve-bit successive-approximation result, voltage and temperature
// - Sixteen single-ended or eight differential channels
// - Single-ended unipolar; differential unipolar or bipolar
// - Frame opens with command byte, MSB first
// - End-of-conversion high on select, trigger, mode 11
// - Oldest unread byte out first, else zero
module ascp_serial_port #(
    parameter int FIFO_DEPTH = ascp_pkg::ASCP_FIFO_DEPTH
) (
    // System
    input wire logic clk,
    input wire logic rst,
    // Serial link from the host
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_din,
    output logic spi_dout,
    output logic spi_dout_oe,
    // Conversion control pins
    input wire logic convert_trigger_n,
    output logic eoc_n,
    output logic trigger_pin_active,
    // Analog front end
    input wire logic cmp_hi,
    output logic [11:0] sar_code,
    output logic [3:0] mux_chan,
    output logic mux_diff,
    output logic range_bipolar,
    output logic temp_sel
);
    // Link domain; all but the byte latch and its toggle held in reset by a high chip select
    logic [2:0] rx_cnt_ff;
    logic [6:0] rx_sh_ff;
    logic seen_rise_ff;
    logic first_ff;
    logic [7:0] rx_byte_ff;
    logic rx_first_ff;
    logic byte_tgl_ff;
    logic [2:0] tx_idx_ff;
    logic tx_par_ff;
    // System domain
    logic [2:0] cs_s_ff;
    logic [2:0] tgl_s_ff;
    logic [2:0] trig_s_ff;
    logic [1:0] cmp_s_ff;
    logic [15:0] src_w_ff;
    logic src_v_ff;
    logic half_ff;
    logic [7:0] slot0_ff;
    logic [7:0] slot1_ff;
    logic [1:0] slv_ff;
    logic cpar_ff;
    logic [1:0] timing_source_select_ff;
    logic [3:0] chan_ff;
    logic temp_ff;
    logic [7:0] uni_ff;
    logic [7:0] bip_ff;
    logic [1:0] expect_ff;
    ascp_pkg::ascp_state_t state_ff;
    logic [11:0] code_ff;
    logic [3:0] bit_ff;
    logic [1:0] settle_ff;
    logic [15:0] result_ff;
    logic eoc_n_ff;
    logic trig_role_ff;
    logic [3:0] mux_chan_ff;
    logic mux_diff_ff;
    logic range_bip_ff;
    logic temp_sel_ff;
    logic f_in_ready;
    logic f_out_valid;
    logic [15:0] f_out_data;

    // Bits are taken on rising edges only while selected
    always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            rx_cnt_ff <= 3'h0;
            rx_sh_ff <= 7'h00;
            seen_rise_ff <= 1'b0;
            first_ff <= 1'b1;
        end else begin
            seen_rise_ff <= 1'b1;
            rx_cnt_ff <= rx_cnt_ff + 3'h1;
            rx_sh_ff <= {rx_sh_ff[5:0], spi_din};
            if (rx_cnt_ff == 3'h7) begin
                first_ff <= 1'b0;
            end
        end
    end

    // Whole bytes leave the link by a toggle; the byte stays put meanwhile
    always_ff @(posedge spi_sclk or posedge rst) begin
        if (rst) begin
            rx_byte_ff <= 8'h00;
            rx_first_ff <= 1'b0;
            byte_tgl_ff <= 1'b0;
        end else if (rx_cnt_ff == 3'h7) begin
            rx_byte_ff <= {rx_sh_ff, spi_din};
            rx_first_ff <= first_ff;
            byte_tgl_ff <= ~byte_tgl_ff;
        end
    end

    // A falling edge before the first rise is the idle-high lead-in
    always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            tx_idx_ff <= 3'h0;
            tx_par_ff <= 1'b0;
        end else if (seen_rise_ff) begin
            tx_idx_ff <= tx_idx_ff + 3'h1;
            if (tx_idx_ff == 3'h7) begin
                tx_par_ff <= ~tx_par_ff;
            end
        end
    end

    // Output path; the slot being shifted is never rewritten mid-byte
    wire [7:0] txs0 = slv_ff[0] ? slot0_ff : 8'h00;
    wire [7:0] txs1 = slv_ff[1] ? slot1_ff : 8'h00;
    wire [7:0] tx_byte = tx_par_ff ? txs1 : txs0;
    wire [2:0] tx_bit = 3'h7 - tx_idx_ff;
    // Pin-timed enable; a flop here would miss the first bit
    assign spi_dout = tx_byte[tx_bit];
    assign spi_dout_oe = ~spi_cs_n;

    // Synchronisers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_s_ff <= 3'h7;
            tgl_s_ff <= 3'h0;
            trig_s_ff <= 3'h7;
            cmp_s_ff <= 2'h0;
        end else begin
            cs_s_ff <= {cs_s_ff[1:0], spi_cs_n};
            tgl_s_ff <= {tgl_s_ff[1:0], byte_tgl_ff};
            trig_s_ff <= {trig_s_ff[1:0], convert_trigger_n};
            cmp_s_ff <= {cmp_s_ff[0], cmp_hi};
        end
    end
    wire cs_idle = cs_s_ff[1];
    wire cs_fall = ~cs_s_ff[1] & cs_s_ff[2];
    wire byte_evt = tgl_s_ff[1] ^ tgl_s_ff[2];
    wire trig_fall = ~trig_s_ff[1] & trig_s_ff[2];
    wire mode_trig = ~timing_source_select_ff[1];

    // Byte source from the result store
    wire [7:0] src_byte = half_ff ? src_w_ff[7:0] : src_w_ff[15:8];
    wire quiet = ~byte_evt & cs_idle;
    wire realign = quiet & cpar_ff;
    wire idle_move = quiet & ~cpar_ff & ~slv_ff[0] & slv_ff[1];
    wire idle_fill0 = quiet & ~cpar_ff & ~slv_ff[0] & ~slv_ff[1] & src_v_ff;
    wire idle_fill1 = quiet & ~cpar_ff & slv_ff[0] & ~slv_ff[1] & src_v_ff;
    wire take_src = src_v_ff & (byte_evt | idle_fill0 | idle_fill1);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            src_w_ff <= 16'h0000;
            src_v_ff <= 1'b0;
            half_ff <= 1'b0;
        end else if (take_src) begin
            src_v_ff <= ~half_ff;
            half_ff <= ~half_ff;
        end else if (!src_v_ff && f_out_valid) begin
            src_w_ff <= f_out_data;
            src_v_ff <= 1'b1;
        end
    end

    // Two presented bytes; consumed slot refills with the next byte
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            slot0_ff <= 8'h00;
            slot1_ff <= 8'h00;
            slv_ff <= 2'h0;
            cpar_ff <= 1'b0;
        end else if (byte_evt) begin
            cpar_ff <= ~cpar_ff;
            if (cpar_ff) begin
                slot1_ff <= src_byte;
                slv_ff[1] <= src_v_ff;
            end else begin
                slot0_ff <= src_byte;
                slv_ff[0] <= src_v_ff;
            end
        end else if (realign) begin
            slot0_ff <= slot1_ff;
            slot1_ff <= slot0_ff;
            slv_ff <= {slv_ff[0], slv_ff[1]};
            cpar_ff <= 1'b0;
        end else if (idle_move) begin
            slot0_ff <= slot1_ff;
            slv_ff <= 2'h1;
        end else if (idle_fill0) begin
            slot0_ff <= src_byte;
            slv_ff[0] <= 1'b1;
        end else if (idle_fill1) begin
            slot1_ff <= src_byte;
            slv_ff[1] <= 1'b1;
        end
    end

    // Command decode; only the frame's first byte is a command
    wire [1:0] cmd_tag =
        rx_byte_ff[ascp_pkg::ASCP_TAG_MSB:ascp_pkg::ASCP_TAG_LSB];
    wire [1:0] cmd_diff =
        rx_byte_ff[ascp_pkg::ASCP_DIFF_MSB:ascp_pkg::ASCP_DIFF_LSB];
    wire cmd_conv = byte_evt & rx_first_ff
        & rx_byte_ff[ascp_pkg::ASCP_CONV_FLAG_BIT];
    wire cmd_setup = byte_evt & rx_first_ff
        & (cmd_tag == ascp_pkg::ASCP_SETUP_TAG);
    wire cmd_range = byte_evt & ~rx_first_ff
        & (expect_ff != ascp_pkg::ASCP_DIFF_NONE);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timing_source_select_ff <= ascp_pkg::ASCP_MODE_RESET;
            chan_ff <= ascp_pkg::ASCP_CHAN_RESET;
            temp_ff <= 1'b0;
            uni_ff <= ascp_pkg::ASCP_PAIR_RESET;
            bip_ff <= ascp_pkg::ASCP_PAIR_RESET;
            expect_ff <= ascp_pkg::ASCP_DIFF_NONE;
        end else begin
            if (cmd_conv) begin
                chan_ff <= rx_byte_ff[ascp_pkg::ASCP_CHAN_MSB:
                                      ascp_pkg::ASCP_CHAN_LSB];
                temp_ff <= rx_byte_ff[ascp_pkg::ASCP_TEMP_BIT];
            end
            if (cmd_setup) begin
                timing_source_select_ff <= rx_byte_ff[ascp_pkg::ASCP_MODE_MSB:
                                                      ascp_pkg::ASCP_MODE_LSB];
                expect_ff <= cmd_diff[1] ? cmd_diff : ascp_pkg::ASCP_DIFF_NONE;
            end else if (cmd_range) begin
                if (expect_ff == ascp_pkg::ASCP_DIFF_BIP) begin
                    bip_ff <= rx_byte_ff;
                end else begin
                    uni_ff <= rx_byte_ff;
                end
                expect_ff <= ascp_pkg::ASCP_DIFF_NONE;
            end else if (cs_idle) begin
                expect_ff <= ascp_pkg::ASCP_DIFF_NONE;
            end
        end
    end

    // Sequencer; trigger pin only counts in modes 00 and 01
    wire [3:0] cmd_chan =
        rx_byte_ff[ascp_pkg::ASCP_CHAN_MSB:ascp_pkg::ASCP_CHAN_LSB];
    wire [3:0] conv_chan = cmd_conv ? cmd_chan : chan_ff;
    wire conv_temp = cmd_conv ? rx_byte_ff[ascp_pkg::ASCP_TEMP_BIT] : temp_ff;
    wire [2:0] pair = conv_chan[3:1];
    wire pair_diff = uni_ff[pair] | bip_ff[pair];
    wire start = (state_ff == ascp_pkg::ASCP_IDLE)
        & ((cmd_conv & ~mode_trig) | (trig_fall & mode_trig));
    wire [11:0] bit_mask = 12'h001 << bit_ff;
    wire [11:0] kept = cmp_s_ff[1] ? code_ff : (code_ff & ~bit_mask);
    wire [11:0] signed_code = {~kept[11], kept[10:0]};
    wire sar_eval = (state_ff == ascp_pkg::ASCP_SAR) & (settle_ff == 2'h0);
    wire push_done = (state_ff == ascp_pkg::ASCP_PUSH) & f_in_ready;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= ascp_pkg::ASCP_IDLE;
            code_ff <= ascp_pkg::ASCP_TRIAL_RESET;
            bit_ff <= ascp_pkg::ASCP_TOP_BIT;
            settle_ff <= ascp_pkg::ASCP_SAR_SETTLE;
            result_ff <= 16'h0000;
            mux_chan_ff <= ascp_pkg::ASCP_CHAN_RESET;
            mux_diff_ff <= 1'b0;
            range_bip_ff <= 1'b0;
            temp_sel_ff <= 1'b0;
        end else begin
            case (state_ff)
                ascp_pkg::ASCP_IDLE: begin
                    if (start) begin
                        mux_chan_ff <= conv_chan;
                        mux_diff_ff <= pair_diff & ~conv_temp;
                        range_bip_ff <= bip_ff[pair] & ~conv_temp;
                        temp_sel_ff <= conv_temp;
                        code_ff <= ascp_pkg::ASCP_TRIAL_RESET;
                        bit_ff <= ascp_pkg::ASCP_TOP_BIT;
                        settle_ff <= ascp_pkg::ASCP_SAR_SETTLE;
                        state_ff <= ascp_pkg::ASCP_SAR;
                    end
                end
                ascp_pkg::ASCP_SAR: begin
                    if (!sar_eval) begin
                        settle_ff <= settle_ff - 2'h1;
                    end else if (bit_ff == 4'h0) begin
                        result_ff <= {4'h0, range_bip_ff ? signed_code : kept};
                        code_ff <= kept;
                        state_ff <= ascp_pkg::ASCP_PUSH;
                    end else begin
                        code_ff <= kept | (bit_mask >> 1);
                        bit_ff <= bit_ff - 4'h1;
                        settle_ff <= ascp_pkg::ASCP_SAR_SETTLE;
                    end
                end
                ascp_pkg::ASCP_PUSH: begin
                    // Stalls here while the store is full
                    if (f_in_ready) begin
                        state_ff <= ascp_pkg::ASCP_IDLE;
                    end
                end
                default: begin
                    state_ff <= ascp_pkg::ASCP_IDLE;
                end
            endcase
        end
    end

    // End-of-conversion and pin role
    wire mode_ext = timing_source_select_ff == ascp_pkg::ASCP_MODE_EXT;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            eoc_n_ff <= 1'b1;
            trig_role_ff <= 1'b0;
        end else begin
            trig_role_ff <= mode_trig;
            if (cs_fall || (trig_fall && mode_trig)
                    || mode_ext) begin
                eoc_n_ff <= 1'b1;
            end else if (push_done) begin
                eoc_n_ff <= 1'b0;
            end
        end
    end

    ascp_fifo #(
        .WIDTH(ascp_pkg::ASCP_WORD_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_store (
        .clk(clk),
        .rst(rst),
        .in_valid(state_ff == ascp_pkg::ASCP_PUSH),
        .in_data(result_ff),
        .in_ready(f_in_ready),
        .out_valid(f_out_valid),
        .out_data(f_out_data),
        .out_ready(~src_v_ff)
    );

    assign eoc_n = eoc_n_ff;
    assign trigger_pin_active = trig_role_ff;
    assign sar_code = code_ff;
    assign mux_chan = mux_chan_ff;
    assign mux_diff = mux_diff_ff;
    assign range_bipolar = range_bip_ff;
    assign temp_sel = temp_sel_ff;
endmodule

`default_nettype wire

// File: verif/ascp_serial_port_properties.sv
// Concurrent checks on the converter serial port pins.
// Assumes a bind to ascp_serial_port; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module ascp_serial_port_properties #(
    parameter int FIFO_DEPTH = 8
) (
    // System
    input wire logic clk,
    input wire logic rst,
    // Serial link
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_din,
    input wire logic spi_dout,
    input wire logic spi_dout_oe,
    // Conversion control
    input wire logic convert_trigger_n,
    input wire logic eoc_n,
    input wire logic trigger_pin_active,
    // Analog front end
    input wire logic cmp_hi,
    input wire logic [11:0] sar_code,
    input wire logic [3:0] mux_chan,
    input wire logic mux_diff,
    input wire logic range_bipolar,
    input wire logic temp_sel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_OE_FOLLOWS_CS: assert property (spi_dout_oe == !spi_cs_n)
        else $error("dout enable disagrees with select");
    AST_DOUT_HOLD_HIGH: assert property (
        (spi_sclk && $past(spi_sclk) && !spi_cs_n && !$past(spi_cs_n))
        |-> $stable(spi_dout)) else $error("dout moved while clock high");
    AST_EOC_CLR_ON_CS: assert property (
        $fell(spi_cs_n) |-> ##[1:5] eoc_n) else $error("eoc not cleared");
    AST_EOC_RESULT_STEADY: assert property (
        $fell(eoc_n) |-> $stable(sar_code) [*4])
        else $error("code moved after eoc");
    AST_SAR_PACE: assert property (
        $changed(sar_code) |=> $stable(sar_code) [*3])
        else $error("trial code paced too fast");
    AST_TRIG_START: assert property (
        (trigger_pin_active && $fell(convert_trigger_n))
        |-> ##[2:6] (sar_code == ascp_pkg::ASCP_TRIAL_RESET))
        else $error("trigger did not start");
    AST_CS_IDLE: assert property (
        (spi_cs_n && !trigger_pin_active) [*8] |-> $stable(mux_chan))
        else $error("channel moved while deselected");
    AST_EOC_AFTER_SAR: assert property (
        $fell(eoc_n) |-> $past(eoc_n, 40)) else $error("eoc too early");
    AST_UNIPOLAR: assert property (
        (temp_sel || !mux_diff) |-> !range_bipolar)
        else $error("bipolar outside differential");
endmodule
`default_nettype wire

// File: verif/ascp_host_model.sv
// Host serial master model driving the converter link.
// Assumes the bench calls frame(); clock stands still between frames.
`timescale 1ns/10ps
`default_nettype none
module ascp_host_model (
    // Serial link
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_din,
    input wire logic spi_dout,
    input wire logic spi_dout_oe
);
    logic cpol = 1'b0;
    logic [7:0] sh = 8'h00;
    logic [7:0] rx[$];
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_din = 1'b0;
    end
    // Idle level set by cpol, 125 ns period
    task automatic frame(int nbits, logic [15:0] tx, logic sel);
        rx.delete();
        spi_sclk = cpol;
        #100;
        spi_cs_n = !sel;
        #62.5;
        for (int i = 0; i < nbits; i++) begin
            spi_sclk = 1'b0;
            spi_din = (i < 16) ? tx[15 - i] : 1'b0;
            #62.5;
            spi_sclk = 1'b1;
            sh = {sh[6:0], spi_dout_oe ? spi_dout : !sh[0]};
            if (i % 8 == 7)
                rx.push_back(sh);
            #62.5;
        end
        spi_sclk = cpol;
        #62.5;
        spi_cs_n = 1'b1;
        // Released data line shows no stale value
        spi_din = !spi_din;
        #300;
    endtask
endmodule
`default_nettype wire

// File: verif/ascp_serial_port_tb.sv
// Self-checking bench of the converter serial port.
// Assumes the host model drives the link; comparator modelled here.
`timescale 1ns/10ps
`default_nettype none
module ascp_serial_port_tb;
    logic clk, rst, trig_n, cmp_hi, eoc_n, tpa;
    logic sclk, cs_n, din, dout, oe, diff, bip, temp;
    logic [11:0] sar, tgt;
    logic [3:0] chan, ch;
    logic [7:0] mq[$];
    logic [31:0] seed = 32'h2FD17456;
    int fails = 0;
    int n_checks = 0;
    bit got, stalled;
    ascp_serial_port #(.FIFO_DEPTH(8)) dut (.clk(clk), .rst(rst),
        .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_din(din), .spi_dout(dout),
        .spi_dout_oe(oe), .convert_trigger_n(trig_n), .eoc_n(eoc_n),
        .trigger_pin_active(tpa), .cmp_hi(cmp_hi), .sar_code(sar),
        .mux_chan(chan), .mux_diff(diff), .range_bipolar(bip),
        .temp_sel(temp));
    ascp_host_model host (.spi_sclk(sclk), .spi_cs_n(cs_n), .spi_din(din),
        .spi_dout(dout), .spi_dout_oe(oe));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Comparator: input at or above the trial code
    always @(posedge clk) begin
        #2;
        cmp_hi = (tgt >= sar);
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Each clocked byte pops one stored byte, zero when empty
    task automatic xfer(int nbits, logic [15:0] tx);
        logic [7:0] e;
        host.frame(nbits, tx, 1'b1);
        foreach (host.rx[i]) begin
            e = mq.size() ? mq.pop_front() : 8'h00;
            check("dout byte", {8'h00, host.rx[i]}, {8'h00, e});
        end
    endtask
    task automatic push(logic [11:0] r);
        mq.push_back({4'h0, r[11:8]});
        mq.push_back(r[7:0]);
    endtask
    task automatic wait_eoc(int lim);
        got = 0;
        for (int i = 0; i < lim && !got; i++) begin
            @(posedge clk);
            #2;
            got = (eoc_n === 1'b0);
        end
    endtask
    task automatic start(logic t);
        ch = 4'(xs());
        tgt = 12'(xs());
        xfer(8, {1'b1, ch, 2'b00, t, 8'h00});
    endtask
    task automatic settle(int lim);
        wait_eoc(lim);
        check("code", 16'(sar), 16'(tgt));
        check("chan", 16'(chan), 16'(ch));
    endtask
    initial begin
        #(40000 * 50);
        fails++;
        tally_and_finish();
    end
    initial begin
        rst = 1'b1;
        trig_n = 1'b1;
        tgt = 12'h000;
        repeat (10) @(posedge clk);
        #2;
        rst = 1'b0;
        check("eoc", 16'(eoc_n), 16'h1);
        check("trig pin", 16'(tpa), 16'h0);
        check("sar", 16'(sar), 16'h800);
        check("oe", 16'(oe), 16'h0);
        repeat (3) @(posedge clk);
        host.cpol = 1'b1;
        xfer(16, 16'h0000);
        host.frame(8, 16'hF800, 1'b0);
        host.frame(3, 16'hE000, 1'b1);
        xfer(8, 16'h0000);
        wait_eoc(100);
        check("no start", 16'(got), 16'h0);
        $display("done idle");
        // Fill the store until a conversion stalls, then drain
        host.cpol = 1'b0;
        stalled = 0;
        for (int k = 0; k < 24 && !stalled; k++) begin
            start(1'b0);
            settle(150);
            stalled = !got;
            push(tgt);
        end
        check("stall", 16'(stalled), 16'h1);
        xfer(8 * (mq.size() + 1), 16'h0000);
        $display("done fill");
        for (int k = 0; k < 3; k++) begin
            xfer(16, {8'h63, (k == 0) ? 8'hFF : 8'h00});
            xfer(16, {8'h62, (k == 1) ? 8'hFF : 8'h00});
            start(k == 2);
            settle(150);
            check("diff", 16'(diff), 16'(k < 2));
            check("bipolar", 16'(bip), 16'(k == 0));
            check("temp", 16'(temp), 16'(k == 2));
            push((k == 0) ? tgt ^ 12'h800 : tgt);
            xfer(16, 16'h0000);
        end
        $display("done ranges");
        for (int m = 0; m < 4; m++) begin
            xfer(8, {2'b01, 2'(m), 12'h000});
            check("trig pin", 16'(tpa), 16'(m < 2));
            start(1'b0);
            if (m < 2) begin
                wait_eoc(80);
                check("cmd ignored", 16'(got), 16'h0);
                @(posedge clk);
                #2 trig_n = 1'b0;
                repeat (4) @(posedge clk);
                #2 trig_n = 1'b1;
            end
            settle(150);
            check("eoc", 16'(got), 16'(m != 3));
            push(tgt);
            xfer(16, 16'h0000);
        end
        $display("done modes");
        tally_and_finish();
    end
endmodule
bind ascp_serial_port ascp_serial_port_properties #(
    .FIFO_DEPTH(FIFO_DEPTH)) chk (.clk(clk), .rst(rst),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_din(spi_din),
    .spi_dout(spi_dout), .spi_dout_oe(spi_dout_oe),
    .convert_trigger_n(convert_trigger_n), .eoc_n(eoc_n),
    .trigger_pin_active(trigger_pin_active), .cmp_hi(cmp_hi),
    .sar_code(sar_code), .mux_chan(mux_chan), .mux_diff(mux_diff),
    .range_bipolar(range_bipolar), .temp_sel(temp_sel));
`default_nettype wire
